// ===== hw/flr_map.vh
// flr_map.vh: offsets, field positions, reset values and codes of the
// fault limit register bank; definitions only, included by bare name.
// How it works
// - Each limit register carries a signed 5-bit exponent in bits 15:11.
// - Each limit register carries a signed 11-bit mantissa in bits 10:0.
// - The over-temperature fault limit is in Celsius and resets to 125.
// - An over-temperature fault sets the temp summary and temp-fault bits and raises both alert and fault outputs.
// - An over-temperature fault turns the output off, it comes back 15 C below the limit, and its action register reads F8.
// - Crossing the warning limit (reset 95 C) sets temp summary and temp-warning bits and raises only the alert.
// - The input overvoltage limit resets to 17 V in memory mode and 14 V in strap mode.
// - An input overvoltage fault sets other, input and input-overvoltage bits and raises the alert.
// - A store-all-defaults command rewrites the input overvoltage limit as its two low bits plus 14.
// - The input overcurrent limit resets to 00FF and a trip sets other, input and input-overcurrent bits and raises the alert.
// - Crossing the output overcurrent warning limit sets other, output-current and warning bits and raises the alert.
// - An input overcurrent fault latches the output off until faults are cleared, raises the fault output, and its action reads C0.
`ifndef FLR_MAP_VH
`define FLR_MAP_VH

`define FLR_EXP_HI 15
`define FLR_EXP_LO 11
`define FLR_MANT_HI 10
`define FLR_MANT_LO 0

// command codes
`define FLR_CMD_CLEAR 8'h03
`define FLR_CMD_STORE_ALL 8'h11
`define FLR_CMD_IOUT_WARN 8'h4A
`define FLR_CMD_OT_FAULT 8'h4F
`define FLR_CMD_OT_ACTION 8'h50
`define FLR_CMD_OT_WARN 8'h51
`define FLR_CMD_VIN_OV 8'h55
`define FLR_CMD_IIN_OC 8'h5B
`define FLR_CMD_IIN_ACTION 8'h5C
`define FLR_CMD_ST_BYTE 8'h78
`define FLR_CMD_ST_WORD 8'h79
`define FLR_CMD_ST_IOUT 8'h7B
`define FLR_CMD_ST_INPUT 8'h7C
`define FLR_CMD_ST_TEMP 8'h7D

// reset values, fixed action codes, store addend and hysteresis
`define FLR_OT_FAULT_RST 16'h007D
`define FLR_OT_WARN_RST 16'h005F
`define FLR_VIN_OV_NVM_RST 16'h0011
`define FLR_VIN_OV_STRAP_RST 16'h000E
`define FLR_IIN_OC_RST 16'h00FF
`define FLR_IOUT_WARN_RST 16'h0050
`define FLR_OT_ACTION_VAL 8'hF8
`define FLR_IIN_ACTION_VAL 8'hC0
`define FLR_VIN_STORE_ADD 16'h000E
`define FLR_OT_HYST 16'h000F

// status bit positions
`define FLR_SB_TEMP 2
`define FLR_SB_OTHER 0
`define FLR_SW_IOUT 14
`define FLR_SW_INPUT 13
`define FLR_ST_OT_FAULT 7
`define FLR_ST_OT_WARN 6
`define FLR_SI_VIN_OV 7
`define FLR_SI_IIN_OC 2
`define FLR_SO_OC_WARN 5

// strap settle count after reset release
`define FLR_STRAP_WAIT 2'h3

`endif

// ===== hw/flr_compare.v
// flr_compare.v: decodes a linear measurement and limit and compares them.
// assumes both inputs come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "flr_map.vh"
module flr_compare (
  input wire clock,
  input wire sys_rst,
  input wire [15:0] meas,
  input wire [15:0] limit,
  input wire [15:0] hyst,
  output reg above_ff,
  output reg below_ff
);

  // mantissa scaled by 2^exp, kept with 8 fraction bits
  function signed [39:0] lin;
    input [15:0] v;
    reg signed [39:0] m;
    reg signed [5:0] e;
    integer sh;
    begin
      m = {{29{v[`FLR_MANT_HI]}}, v[`FLR_MANT_HI:`FLR_MANT_LO]};
      e = {v[`FLR_EXP_HI], v[`FLR_EXP_HI:`FLR_EXP_LO]};
      sh = e + 8;
      if (sh >= 0) begin
        lin = m <<< sh;
      end else begin
        lin = m >>> (-sh); // small exponents lose sub-1/256 precision
      end
    end
  endfunction

  wire signed [39:0] meas_v;
  wire signed [39:0] lim_v;
  wire signed [39:0] rel_v;
  assign meas_v = lin(meas);
  assign lim_v = lin(limit);
  assign rel_v = lim_v - lin(hyst);

  // registered compare, one cycle after the inputs
  always @(posedge clock) begin
    if (sys_rst) begin
      above_ff <= 1'b0;
      below_ff <= 1'b0;
    end else begin
      above_ff <= (meas_v > lim_v);
      below_ff <= (meas_v <= rel_v);
    end
  end

endmodule
`default_nettype wire

// ===== hw/flr_bank.v
// flr_bank.v: fault and warning limit registers with trip, status and
// output-off handling. registers are reached by command code through a
// simple strobe port fed by the bus protocol engine; measurements arrive
// in linear format from telemetry logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "flr_map.vh"
module flr_bank (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] reg_cmd,
  input wire reg_wr_en,
  input wire [15:0] reg_wr_data,
  output reg [15:0] reg_rd_data_ff,
  input wire strap_mode_pin,
  input wire [15:0] meas_temp,
  input wire [15:0] meas_vin,
  input wire [15:0] meas_iin,
  input wire [15:0] meas_iout,
  output reg host_alert_out,
  output reg regulator_fault_out,
  output reg output_enable_out
);

  localparam NCH = 5;

  // limit registers
  reg [15:0] ot_fault_ff;
  reg [15:0] ot_warn_ff;
  reg [15:0] vin_ov_ff;
  reg [15:0] iin_oc_ff;
  reg [15:0] iout_warn_ff;

  // sticky status
  reg st_ot_fault_ff;
  reg st_ot_warn_ff;
  reg st_vin_ov_ff;
  reg st_iin_oc_ff;
  reg st_oc_warn_ff;
  reg ot_off_ff;
  reg iin_off_ff;

  // strap pin synchroniser and settle counter
  reg strap_s1_ff;
  reg strap_s2_ff;
  reg strap_s3_ff;
  reg [1:0] strap_cnt_ff;
  reg strap_done_ff;

  wire wr_ot_fault = reg_wr_en && (reg_cmd == `FLR_CMD_OT_FAULT);
  wire wr_ot_warn = reg_wr_en && (reg_cmd == `FLR_CMD_OT_WARN);
  wire wr_vin_ov = reg_wr_en && (reg_cmd == `FLR_CMD_VIN_OV);
  wire wr_iin_oc = reg_wr_en && (reg_cmd == `FLR_CMD_IIN_OC);
  wire wr_iout = reg_wr_en && (reg_cmd == `FLR_CMD_IOUT_WARN);
  wire do_clear = reg_wr_en && (reg_cmd == `FLR_CMD_CLEAR);
  wire do_store = reg_wr_en && (reg_cmd == `FLR_CMD_STORE_ALL);

  // per-channel compare: 0 ot fault, 1 ot warn, 2 vin ov, 3 iin oc, 4 iout
  wire [16*NCH-1:0] meas_all;
  wire [16*NCH-1:0] lim_all;
  wire [NCH-1:0] above;
  wire [NCH-1:0] below;
  assign meas_all = {meas_iout, meas_iin, meas_vin, meas_temp, meas_temp};
  assign lim_all = {iout_warn_ff, iin_oc_ff, vin_ov_ff, ot_warn_ff,
    ot_fault_ff};

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_cmp
      flr_compare u_cmp (
        .clock(clock),
        .sys_rst(sys_rst),
        .meas(meas_all[16*gi+15:16*gi]),
        .limit(lim_all[16*gi+15:16*gi]),
        .hyst((gi == 0) ? `FLR_OT_HYST : 16'h0000),
        .above_ff(above[gi]),
        .below_ff(below[gi])
      );
    end
  endgenerate

  // strap level seen only once the second and third stages agree
  always @(posedge clock) begin
    if (sys_rst) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
      strap_s3_ff <= 1'b0;
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else begin
      strap_s1_ff <= strap_mode_pin;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      if (strap_cnt_ff != `FLR_STRAP_WAIT) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end else if (strap_s2_ff == strap_s3_ff) begin
        strap_done_ff <= 1'b1;
      end
    end
  end

  wire strap_load = (strap_cnt_ff == `FLR_STRAP_WAIT) && !strap_done_ff &&
    (strap_s2_ff == strap_s3_ff);

  // limit registers; host writes win over the reset-time strap default
  always @(posedge clock) begin
    if (sys_rst) begin
      ot_fault_ff <= `FLR_OT_FAULT_RST;
      ot_warn_ff <= `FLR_OT_WARN_RST;
      vin_ov_ff <= `FLR_VIN_OV_NVM_RST;
      iin_oc_ff <= `FLR_IIN_OC_RST;
      iout_warn_ff <= `FLR_IOUT_WARN_RST;
    end else begin
      if (wr_ot_fault) begin
        ot_fault_ff <= reg_wr_data;
      end
      if (wr_ot_warn) begin
        ot_warn_ff <= reg_wr_data;
      end
      if (wr_iin_oc) begin
        iin_oc_ff <= reg_wr_data;
      end
      if (wr_iout) begin
        iout_warn_ff <= reg_wr_data;
      end
      if (wr_vin_ov) begin
        vin_ov_ff <= reg_wr_data;
      end else if (do_store) begin
        vin_ov_ff <= {14'h0000, vin_ov_ff[1:0]} + `FLR_VIN_STORE_ADD;
      end else if (strap_load && strap_s3_ff) begin
        vin_ov_ff <= `FLR_VIN_OV_STRAP_RST;
      end
    end
  end

  // sticky status: a trip in the clear cycle stays set
  always @(posedge clock) begin
    if (sys_rst) begin
      st_ot_fault_ff <= 1'b0;
      st_ot_warn_ff <= 1'b0;
      st_vin_ov_ff <= 1'b0;
      st_iin_oc_ff <= 1'b0;
      st_oc_warn_ff <= 1'b0;
    end else begin
      st_ot_fault_ff <= above[0] | (st_ot_fault_ff & ~do_clear);
      st_ot_warn_ff <= above[1] | (st_ot_warn_ff & ~do_clear);
      st_vin_ov_ff <= above[2] | (st_vin_ov_ff & ~do_clear);
      st_iin_oc_ff <= above[3] | (st_iin_oc_ff & ~do_clear);
      st_oc_warn_ff <= above[4] | (st_oc_warn_ff & ~do_clear);
    end
  end

  // output-off latches: temperature recovers by itself, input
  // overcurrent waits for a clear and never retries
  always @(posedge clock) begin
    if (sys_rst) begin
      ot_off_ff <= 1'b0;
      iin_off_ff <= 1'b0;
    end else begin
      if (above[0]) begin
        ot_off_ff <= 1'b1;
      end else if (below[0]) begin
        ot_off_ff <= 1'b0;
      end
      if (above[3]) begin
        iin_off_ff <= 1'b1;
      end else if (do_clear) begin
        iin_off_ff <= 1'b0;
      end
    end
  end

  // summary bytes built from the sticky bits and the output-enable state
  wire [7:0] st_byte;
  wire [15:0] st_word;
  wire [7:0] st_temp;
  wire [7:0] st_input;
  wire [7:0] st_iout;
  assign st_temp = {st_ot_fault_ff, st_ot_warn_ff, 6'h00};
  assign st_input = {st_vin_ov_ff, 4'h0, st_iin_oc_ff, 2'h0};
  assign st_iout = {2'h0, st_oc_warn_ff, 5'h00};
  assign st_byte = {1'b0, ~output_enable_out, 3'h0,
    st_ot_fault_ff | st_ot_warn_ff, 1'b0,
    st_vin_ov_ff | st_iin_oc_ff | st_oc_warn_ff};
  assign st_word = {1'b0, st_oc_warn_ff,
    st_vin_ov_ff | st_iin_oc_ff, 5'h00, st_byte};

  // fixed action codes; read-only, so host writes to them are dropped
  wire [15:0] ot_action_word;
  wire [15:0] iin_action_word;
  assign ot_action_word = {8'h00, `FLR_OT_ACTION_VAL};
  assign iin_action_word = {8'h00, `FLR_IIN_ACTION_VAL};

  // outputs: every sticky bit alerts, only faults that stop power flag
  always @(posedge clock) begin
    if (sys_rst) begin
      host_alert_out <= 1'b0;
      regulator_fault_out <= 1'b0;
      output_enable_out <= 1'b1;
    end else begin
      host_alert_out <= st_ot_fault_ff | st_ot_warn_ff | st_vin_ov_ff |
        st_iin_oc_ff | st_oc_warn_ff;
      regulator_fault_out <= st_ot_fault_ff | st_iin_oc_ff;
      output_enable_out <= ~(ot_off_ff | iin_off_ff | above[0] |
        above[3]);
    end
  end

  // read data one cycle after the command code; unknown codes read zero
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rd_data_ff <= 16'h0000;
    end else begin
      case (reg_cmd)
        `FLR_CMD_IOUT_WARN: reg_rd_data_ff <= iout_warn_ff;
        `FLR_CMD_OT_FAULT: reg_rd_data_ff <= ot_fault_ff;
        `FLR_CMD_OT_ACTION: reg_rd_data_ff <= ot_action_word;
        `FLR_CMD_OT_WARN: reg_rd_data_ff <= ot_warn_ff;
        `FLR_CMD_VIN_OV: reg_rd_data_ff <= vin_ov_ff;
        `FLR_CMD_IIN_OC: reg_rd_data_ff <= iin_oc_ff;
        `FLR_CMD_IIN_ACTION: reg_rd_data_ff <= iin_action_word;
        `FLR_CMD_ST_BYTE: reg_rd_data_ff <= {8'h00, st_byte};
        `FLR_CMD_ST_WORD: reg_rd_data_ff <= st_word;
        `FLR_CMD_ST_IOUT: reg_rd_data_ff <= {8'h00, st_iout};
        `FLR_CMD_ST_INPUT: reg_rd_data_ff <= {8'h00, st_input};
        `FLR_CMD_ST_TEMP: reg_rd_data_ff <= {8'h00, st_temp};
        default: reg_rd_data_ff <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tb/flr_checker_assertions.sv
// flr_checker: timing checks on the fault limit bank ports.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module flr_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wr_data,
  input wire logic [15:0] reg_rd_data_ff,
  input wire logic host_alert_out,
  input wire logic regulator_fault_out,
  input wire logic output_enable_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // write then hold the same code: readback lands one cycle later
  sequence wr_ot_s;
    reg_wr_en && reg_cmd == 8'h4F ##1 !reg_wr_en && reg_cmd == 8'h4F;
  endsequence
  // store strobe, one idle edge, then the limit code is put up for reading
  sequence store_s;
    reg_wr_en && reg_cmd == 8'h11 ##1 !reg_wr_en ##1
      !reg_wr_en && reg_cmd == 8'h55;
  endsequence
  a_fault_alert:
  assert property (regulator_fault_out |-> host_alert_out)
    else $error("fault output without alert");
  // alert and fault outputs drop only two edges after a clear write
  a_alert_clear:
  assert property ($fell(host_alert_out) && !$past(sys_rst) |->
    $past(reg_wr_en, 2) && $past(reg_cmd, 2) == 8'h03)
    else $error("alert dropped without clear");
  a_fault_clear:
  assert property ($fell(regulator_fault_out) && !$past(sys_rst) |->
    $past(reg_wr_en && reg_cmd == 8'h03, 2))
    else $error("fault dropped without clear");
  a_off_faults:
  assert property ($fell(output_enable_out) |=> regulator_fault_out)
    else $error("output off without fault output");
  a_act_ot:
  assert property (reg_cmd == 8'h50 |=> reg_rd_data_ff == 16'h00F8)
    else $error("temp action value wrong");
  a_act_iin:
  assert property (reg_cmd == 8'h5C |=> reg_rd_data_ff == 16'h00C0)
    else $error("input current action value wrong");
  a_limit_back:
  assert property (wr_ot_s |=> reg_rd_data_ff == $past(reg_wr_data, 2))
    else $error("limit readback differs from write");
  a_store_sum:
  assert property (store_s |=> reg_rd_data_ff >= 16'h000E
    && reg_rd_data_ff <= 16'h0011) else $error("stored limit out of range");
endmodule
`default_nettype wire

// ===== tb/flr_host_model.sv
// flr_host_model: host side issuing register writes and reads.
// assumes the bank takes a write on the edge that sees the strobe.
`timescale 1ns/10ps
`default_nettype none
module flr_host_model (
  input wire logic clock,
  input wire logic [15:0] reg_rd_data_ff,
  output var logic [7:0] reg_cmd,
  output var logic reg_wr_en,
  output var logic [15:0] reg_wr_data
);
  initial begin
    reg_cmd = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 16'h0000;
  end
  // one-cycle strobe; data turns stale-inverted once taken
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clock);
    reg_cmd <= c;
    reg_wr_en <= 1'b1;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_wr_data <= ~d;
  endtask
  // code held two edges so the registered answer is settled
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clock);
    reg_cmd <= c;
    repeat (2) @(posedge clock);
    d = reg_rd_data_ff;
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// testbench: drives the fault limit bank via the host model and the
// measurement inputs; one 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic strap_mode_pin = 1'b0;
  logic [15:0] meas_temp = 16'h0000;
  logic [15:0] meas_vin = 16'h0000;
  logic [15:0] meas_iin = 16'h0000;
  logic [15:0] meas_iout = 16'h0000;
  wire [7:0] reg_cmd;
  wire reg_wr_en;
  wire [15:0] reg_wr_data;
  wire [15:0] reg_rd_data_ff;
  wire host_alert_out;
  wire regulator_fault_out;
  wire output_enable_out;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  // code and expected reset value; 0x20 is unmapped
  logic [23:0] rows [0:9] = '{24'h4F007D, 24'h5000F8, 24'h51005F,
    24'h550011, 24'h5B00FF, 24'h4A0050, 24'h5C00C0, 24'h780000,
    24'h7D0000, 24'h200000};
  flr_bank uut (.clock(clock), .sys_rst(sys_rst), .reg_cmd(reg_cmd),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data_ff(reg_rd_data_ff), .strap_mode_pin(strap_mode_pin),
    .meas_temp(meas_temp), .meas_vin(meas_vin), .meas_iin(meas_iin),
    .meas_iout(meas_iout), .host_alert_out(host_alert_out),
    .regulator_fault_out(regulator_fault_out),
    .output_enable_out(output_enable_out));
  flr_host_model host (.clock(clock), .reg_rd_data_ff(reg_rd_data_ff),
    .reg_cmd(reg_cmd), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data));
  always #2.5 clock = ~clock;
  task automatic summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // run is about 200 cycles; a hang is cut at 3000
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      $display("[ERR] timeout expected 0 seen %0d", cycles);
      summarize();
    end
  end
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    host.rd(c, d);
    chk($sformatf("reg %h", c), e, d);
  endtask
  // trip path is three edges; six leaves margin for the input edge
  task automatic pins(input logic [2:0] e);
    repeat (6) @(posedge clock);
    chk("alert fault enable", {13'h0, e},
      {13'h0, host_alert_out, regulator_fault_out, output_enable_out});
  endtask
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    foreach (rows[i]) begin
      rc(rows[i][23:16], rows[i][15:0]);
    end
    $display("test reset values done");
    host.wr(8'h4F, 16'hF8C3);
    rc(8'h4F, 16'hF8C3);
    host.wr(8'h50, 16'hFFFF);
    rc(8'h50, 16'h00F8);
    host.wr(8'h4F, 16'h007D);
    host.wr(8'h55, 16'h1235);
    host.wr(8'h11, 16'h0000);
    rc(8'h55, 16'h000F);
    host.wr(8'h55, 16'h0011);
    $display("test access done");
    @(posedge clock) meas_temp <= 16'h005F;
    pins(3'b001);
    @(posedge clock) meas_temp <= 16'h0060;
    pins(3'b101);
    rc(8'h7D, 16'h0040);
    @(posedge clock) meas_temp <= 16'h007E;
    pins(3'b110);
    rc(8'h78, 16'h0044);
    rc(8'h7D, 16'h00C0);
    @(posedge clock) meas_temp <= 16'h006F;
    pins(3'b110);
    @(posedge clock) meas_temp <= 16'h006E;
    pins(3'b111);
    @(posedge clock) meas_temp <= 16'h0000;
    host.wr(8'h03, 16'h0000);
    pins(3'b001);
    $display("test temperature done");
    @(posedge clock) meas_vin <= 16'h0012;
    pins(3'b101);
    rc(8'h79, 16'h2001);
    rc(8'h7C, 16'h0080);
    @(posedge clock) meas_vin <= 16'h0000;
    host.wr(8'h03, 16'h0000);
    @(posedge clock) meas_iin <= 16'h0100;
    pins(3'b110);
    rc(8'h7C, 16'h0004);
    @(posedge clock) meas_iin <= 16'h0000;
    pins(3'b110);
    host.wr(8'h03, 16'h0000);
    pins(3'b001);
    $display("test input faults done");
    host.wr(8'h4A, 16'h0828);
    @(posedge clock) meas_iout <= 16'h0050;
    pins(3'b001);
    @(posedge clock) meas_iout <= 16'h0051;
    pins(3'b101);
    rc(8'h7B, 16'h0020);
    rc(8'h79, 16'h4001);
    $display("test output warning done");
    @(posedge clock) strap_mode_pin <= 1'b1;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    rc(8'h55, 16'h000E);
    $display("test strap done");
    summarize();
  end
endmodule
bind flr_bank flr_checker chk_i (.clock(clock), .sys_rst(sys_rst),
  .reg_cmd(reg_cmd), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_data_ff(reg_rd_data_ff), .host_alert_out(host_alert_out),
  .regulator_fault_out(regulator_fault_out),
  .output_enable_out(output_enable_out));
`default_nettype wire
